/* rtl/dual_adc_map.vh */
// constants for the dual converter output formatting block
`ifndef DUAL_ADC_MAP_VH
`define DUAL_ADC_MAP_VH
`define SAMPLE_W 12
`define SAMPLE_MSB 11
`define LEVEL_W 2
`define LEVEL_GND 2'h0
`define LEVEL_THIRD 2'h1
`define LEVEL_TWO_THIRDS 2'h2
`define LEVEL_FULL 2'h3
`define CODE_MID 12'h800
`define CODE_MAX 12'hfff
`define CODE_MIN 12'h000
`define RAW_W 14
`define RAW_MAX 14'h0fff
`define RELOCK_CYCLES 100
`define RELOCK_W 7
`define RELOCK_LAST 7'h63
`define STOP_LIMIT 8'hff
`define STOP_W 8
`endif

/* rtl/stab_lock.v */
// duty-cycle stabilizer lock tracker for one sample clock
`timescale 1ns/1ps
module stab_lock (
    // clock and reset
    input wire clk,
    input wire arst_n,
    // control
    input wire stab_on,
    input wire clk_running,
    // status
    output wire locked
);
`include "dual_adc_map.vh"
    reg [`RELOCK_W-1:0] cnt_q;
    reg [`RELOCK_W-1:0] cnt_d;
    reg locked_q;
    reg locked_d;
    always @* begin
        cnt_d = cnt_q;
        locked_d = locked_q;
        if (!stab_on) begin
            cnt_d = {`RELOCK_W{1'b0}};
            locked_d = 1'b1;
        end else if (!clk_running) begin
            // a long stop drops lock
            cnt_d = {`RELOCK_W{1'b0}};
            locked_d = 1'b0;
        end else if (!locked_q) begin
            if (cnt_q == `RELOCK_LAST) begin
                locked_d = 1'b1; // RULE9
            end else begin
                cnt_d = cnt_q + 1'b1;
            end
        end
    end
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= {`RELOCK_W{1'b0}};
            locked_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            locked_q <= locked_d;
        end
    end
    assign locked = locked_q;
endmodule // stab_lock

/* rtl/dual_adc_fmt.v */
// dual channel 12-bit sample formatting, overrange and output enable
// Operation
// RULE1: low two mode levels offset binary, high two complement
// RULE2: stabilizer on only at middle two levels
// RULE3: one mode setting drives both channels
// RULE4: offset binary midscale 800, complement flips top bit
// RULE5: overrange flags and clamps to extreme code
// RULE6: high enable-bar disables data and flag
// RULE7: separate enable per channel
// RULE8: sample on rising edge only, ignore falling
// RULE9: about hundred cycles relock, samples marked invalid
// RULE10: source keeps rate between 1 and 10 Msps
// RULE11: no stabilizer needs 50 percent duty, 40ns halves
// RULE12: channel clocks synchronous, skew within 1ns
// RULE13: word and flag from same sampled edge
`timescale 1ns/1ps
module dual_adc_fmt (
    // clock and reset
    input wire clk,
    input wire arst_n,
    // configuration
    input wire [1:0] mode_level,
    // sample clocks from pins
    input wire chan_a_sample_clock,
    input wire chan_b_sample_clock,
    // raw conversion results, signed, wider than the output
    input wire [13:0] chan_a_raw,
    input wire [13:0] chan_b_raw,
    // output enables, active low
    input wire chan_a_output_enable_n,
    input wire chan_b_output_enable_n,
    // channel a outputs
    output wire [11:0] chan_a_sample_word,
    output wire chan_a_overrange_flag,
    output wire chan_a_drive_n,
    output wire chan_a_sample_valid,
    // channel b outputs
    output wire [11:0] chan_b_sample_word,
    output wire chan_b_overrange_flag,
    output wire chan_b_drive_n,
    output wire chan_b_sample_valid,
    // mode status
    output wire twos_complement,
    output wire stabilizer_on
);
`include "dual_adc_map.vh"
    // clamp a signed raw value to a 12-bit offset binary or two's complement code
    function [`SAMPLE_W:0] fmt_code;
        input [`RAW_W-1:0] raw;
        input twos;
        reg [`RAW_W-1:0] biased;
        reg [`SAMPLE_W-1:0] code;
        reg ovr;
        begin
            biased = raw + {2'h0, `CODE_MID};
            ovr = 1'b0;
            code = biased[`SAMPLE_W-1:0]; // RULE4
            // judge by the raw sign; a large positive sum wraps into the top bit
            if (raw[`RAW_W-1] && biased[`RAW_W-1]) begin
                code = `CODE_MIN; // RULE5
                ovr = 1'b1;
            end else if (!raw[`RAW_W-1] && (biased > `RAW_MAX)) begin
                code = `CODE_MAX; // RULE5
                ovr = 1'b1;
            end
            if (twos) begin
                code[`SAMPLE_MSB] = ~code[`SAMPLE_MSB]; // RULE4
            end
            fmt_code = {ovr, code};
        end
    endfunction

    // next stable level: follow stage three only once stage two agrees
    function settle;
        input [2:0] sync;
        input lvl;
        begin
            settle = (sync[1] == sync[2]) ? sync[2] : lvl;
        end
    endfunction

    // idle count: cleared by a rise, held once it reaches the stop limit
    function [`STOP_W-1:0] idle_next;
        input [`STOP_W-1:0] idle;
        input rise;
        begin
            idle_next = idle;
            if (rise) begin
                idle_next = {`STOP_W{1'b0}};
            end else if (idle != `STOP_LIMIT) begin
                idle_next = idle + 1'b1;
            end
        end
    endfunction

    // mode level decode; both channels read the same two bits
    function is_twos;
        input [`LEVEL_W-1:0] lvl;
        begin
            is_twos = (lvl == `LEVEL_TWO_THIRDS) || (lvl == `LEVEL_FULL);
        end
    endfunction

    function is_stab;
        input [`LEVEL_W-1:0] lvl;
        begin
            is_stab = (lvl == `LEVEL_THIRD) || (lvl == `LEVEL_TWO_THIRDS);
        end
    endfunction

    // mode decode, shared by both channels
    reg twos_q;
    reg stab_q;
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            twos_q <= 1'b0;
            stab_q <= 1'b0;
        end else begin
            twos_q <= is_twos(mode_level); // RULE1
            stab_q <= is_stab(mode_level); // RULE2
        end
    end
    assign twos_complement = twos_q;
    assign stabilizer_on = stab_q;

    // three-stage pin synchronisers for the sample clocks
    reg [2:0] a_sync_q;
    reg [2:0] b_sync_q;
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            a_sync_q <= 3'h0;
            b_sync_q <= 3'h0;
        end else begin
            a_sync_q <= {a_sync_q[1:0], chan_a_sample_clock};
            b_sync_q <= {b_sync_q[1:0], chan_b_sample_clock};
        end
    end
    // stable level once stages two and three agree
    reg a_lvl_q;
    reg b_lvl_q;
    reg a_lvl_d;
    reg b_lvl_d;
    always @* begin
        a_lvl_d = settle(a_sync_q, a_lvl_q);
        b_lvl_d = settle(b_sync_q, b_lvl_q);
    end
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            a_lvl_q <= 1'b0;
            b_lvl_q <= 1'b0;
        end else begin
            a_lvl_q <= a_lvl_d;
            b_lvl_q <= b_lvl_d;
        end
    end
    // falling edges are never used
    wire a_rise = a_lvl_d & ~a_lvl_q; // RULE8
    wire b_rise = b_lvl_d & ~b_lvl_q; // RULE8

    // stopped-clock watchdogs; source rate floor keeps these from tripping in use
    reg [`STOP_W-1:0] a_idle_q;
    reg [`STOP_W-1:0] b_idle_q;
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            a_idle_q <= {`STOP_W{1'b0}};
            b_idle_q <= {`STOP_W{1'b0}};
        end else begin
            a_idle_q <= idle_next(a_idle_q, a_rise);
            b_idle_q <= idle_next(b_idle_q, b_rise);
        end
    end
    wire a_locked;
    wire b_locked;
    // lock counters advance on clk; relock window is in system cycles
    stab_lock u_lock_a (
        .clk(clk),
        .arst_n(arst_n),
        .stab_on(stab_q),
        .clk_running(a_idle_q != `STOP_LIMIT),
        .locked(a_locked)
    );
    stab_lock u_lock_b (
        .clk(clk),
        .arst_n(arst_n),
        .stab_on(stab_q),
        .clk_running(b_idle_q != `STOP_LIMIT),
        .locked(b_locked)
    );

    // capture word, flag and valid together on each rising edge
    reg [`SAMPLE_W:0] a_out_q;
    reg [`SAMPLE_W:0] b_out_q;
    reg a_val_q;
    reg b_val_q;
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            a_out_q <= {1'b0, `CODE_MID};
            b_out_q <= {1'b0, `CODE_MID};
            a_val_q <= 1'b0;
            b_val_q <= 1'b0;
        end else begin
            if (a_rise) begin
                a_out_q <= fmt_code(chan_a_raw, twos_q); // RULE13 RULE3
                a_val_q <= a_locked; // RULE9
            end
            if (b_rise) begin
                b_out_q <= fmt_code(chan_b_raw, twos_q); // RULE13 RULE3
                b_val_q <= b_locked; // RULE9
            end
        end
    end

    // outputs park at zero while disabled; drive_n tells the pad to float
    assign chan_a_sample_word = chan_a_output_enable_n ? `CODE_MIN : a_out_q[`SAMPLE_W-1:0]; // RULE6 RULE7
    assign chan_a_overrange_flag = ~chan_a_output_enable_n & a_out_q[`SAMPLE_W]; // RULE6
    assign chan_a_drive_n = chan_a_output_enable_n; // RULE7
    assign chan_a_sample_valid = ~chan_a_output_enable_n & a_val_q;
    assign chan_b_sample_word = chan_b_output_enable_n ? `CODE_MIN : b_out_q[`SAMPLE_W-1:0]; // RULE6 RULE7
    assign chan_b_overrange_flag = ~chan_b_output_enable_n & b_out_q[`SAMPLE_W]; // RULE6
    assign chan_b_drive_n = chan_b_output_enable_n; // RULE7
    assign chan_b_sample_valid = ~chan_b_output_enable_n & b_val_q;
endmodule // dual_adc_fmt

/* tb/dual_adc_fmt_asserts.sv */
// concurrent checks on the dual converter formatting ports
`timescale 1ns/1ps
module dual_adc_fmt_asserts (
    // clock, reset, mode
    input wire clk,
    input wire arst_n,
    input wire [1:0] mode_level,
    input wire chan_a_sample_clock,
    input wire chan_b_sample_clock,
    // enables and outputs
    input wire chan_a_output_enable_n,
    input wire chan_b_output_enable_n,
    input wire [11:0] chan_a_sample_word,
    input wire chan_a_overrange_flag,
    input wire chan_a_drive_n,
    input wire chan_a_sample_valid,
    input wire [11:0] chan_b_sample_word,
    input wire chan_b_overrange_flag,
    input wire chan_b_drive_n,
    input wire chan_b_sample_valid,
    input wire twos_complement,
    input wire stabilizer_on
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    sequence s_a_dark;
        chan_a_sample_word == 12'h000 && !chan_a_overrange_flag && !chan_a_sample_valid;
    endsequence
    sequence s_pin_held;
        $past(chan_a_sample_clock, 1) && $past(chan_a_sample_clock, 2);
    endsequence
    sequence s_b_pin_held;
        $past(chan_b_sample_clock, 1) && $past(chan_b_sample_clock, 2);
    endsequence
    property p_a_off; chan_a_output_enable_n |-> s_a_dark; endproperty
    a_a_off: assert property (p_a_off) else $error("channel a not dark");
    property p_b_off;
        chan_b_output_enable_n |-> chan_b_sample_word == 12'h000 && !chan_b_overrange_flag
            && !chan_b_sample_valid;
    endproperty
    a_b_off: assert property (p_b_off) else $error("channel b not dark");
    property p_pad; chan_a_drive_n == chan_a_output_enable_n; endproperty
    a_pad: assert property (p_pad) else $error("pad enable wrong");
    property p_b_pad; chan_b_drive_n == chan_b_output_enable_n; endproperty
    a_b_pad: assert property (p_b_pad) else $error("channel b pad enable wrong");
    property p_twos; $past(arst_n) |-> twos_complement == $past(mode_level[1]); endproperty
    a_twos: assert property (p_twos) else $error("format decode wrong");
    property p_stab;
        $past(arst_n) |-> stabilizer_on == ($past(mode_level) == 2'h1 || $past(mode_level) == 2'h2);
    endproperty
    a_stab: assert property (p_stab) else $error("stabilizer decode wrong");
    property p_a_clamp;
        chan_a_overrange_flag |-> chan_a_sample_word[10:0] == 11'h7ff || chan_a_sample_word[10:0] == 11'h000;
    endproperty
    a_a_clamp: assert property (p_a_clamp) else $error("channel a not clamped");
    property p_b_clamp;
        chan_b_overrange_flag |-> chan_b_sample_word[10:0] == 11'h7ff || chan_b_sample_word[10:0] == 11'h000;
    endproperty
    a_b_clamp: assert property (p_b_clamp) else $error("channel b not clamped");
    // word may only move after a pin rise, not on a fall
    property p_a_load;
        $changed(chan_a_sample_word) && $stable(chan_a_output_enable_n) && $stable(twos_complement)
            |-> s_pin_held;
    endproperty
    a_a_load: assert property (p_a_load) else $error("word moved without pin rise");
    property p_b_load;
        $changed(chan_b_sample_word) && $stable(chan_b_output_enable_n) && $stable(twos_complement)
            |-> s_b_pin_held;
    endproperty
    a_b_load: assert property (p_b_load) else $error("b word moved without rise");
    // flag is captured with its word, so it too only moves after a pin rise
    property p_a_flag;
        $changed(chan_a_overrange_flag) && $stable(chan_a_output_enable_n) |-> s_pin_held;
    endproperty
    a_a_flag: assert property (p_a_flag) else $error("a flag moved without rise");
    property p_b_flag;
        $changed(chan_b_overrange_flag) && $stable(chan_b_output_enable_n) |-> s_b_pin_held;
    endproperty
    a_b_flag: assert property (p_b_flag) else $error("b flag moved without rise");
endmodule // dual_adc_fmt_asserts
bind dual_adc_fmt dual_adc_fmt_asserts u_dual_adc_fmt_asserts (.*);

/* tb/sample_capture.sv */
// receiving logic that latches both sample words on the pin clock fall
`timescale 1ns/1ps
module sample_capture (
    // pin clock and captured buses
    input wire pin_clock,
    input wire [11:0] a_word,
    input wire a_flag,
    input wire a_valid,
    input wire [11:0] b_word,
    input wire b_flag,
    input wire b_valid,
    output reg [27:0] cap,
    output reg got = 1'b0
);
    // words settle a few clocks after the rise, so the fall is the safe point
    always @(negedge pin_clock) begin
        // valid low marks a sample taken while relocking or with its output disabled, to be discarded
        cap <= {a_valid, a_flag, a_word, b_valid, b_flag, b_word};
        got <= ~got;
    end
endmodule // sample_capture

/* tb/dual_adc_fmt_test.sv */
// self-checking bench for the dual converter formatting block
`timescale 1ns/1ps
module dual_adc_fmt_test;
    reg clk = 1'b0;
    reg arst_n = 1'b0;
    reg [1:0] mode_level = 2'h0;
    reg pin = 1'b0;
    reg [13:0] raw_a = 14'h0000;
    reg [13:0] raw_b = 14'h0000;
    reg oe_a_n = 1'b0;
    reg oe_b_n = 1'b0;
    wire [11:0] word_a, word_b;
    wire flag_a, flag_b, valid_a, valid_b, twos, stab, got;
    wire [27:0] cap;
    logic [27:0] exp_q[$];
    integer failures = 0;
    integer check_count = 0;
    integer cycles = 0;
    integer m, n;
    // pin half period, relock window and a stop long enough to drop lock
    localparam integer half_cycles = 12;
    localparam integer relock_cycles = 100;
    localparam integer stop_cycles = 300;
    dual_adc_fmt u_dual_adc_fmt (.clk(clk), .arst_n(arst_n), .mode_level(mode_level),
        .chan_a_sample_clock(pin), .chan_b_sample_clock(pin), .chan_a_raw(raw_a),
        .chan_b_raw(raw_b), .chan_a_output_enable_n(oe_a_n), .chan_b_output_enable_n(oe_b_n),
        .chan_a_sample_word(word_a), .chan_a_overrange_flag(flag_a), .chan_a_drive_n(),
        .chan_a_sample_valid(valid_a), .chan_b_sample_word(word_b),
        .chan_b_overrange_flag(flag_b), .chan_b_drive_n(), .chan_b_sample_valid(valid_b),
        .twos_complement(twos), .stabilizer_on(stab));
    sample_capture u_sample_capture (.pin_clock(pin), .a_word(word_a), .a_flag(flag_a),
        .a_valid(valid_a), .b_word(word_b), .b_flag(flag_b), .b_valid(valid_b), .cap(cap),
        .got(got));
    function [13:0] fmt(input [13:0] raw, input tw, input off, input v);
        reg [11:0] w;
        reg o;
        begin
            o = $signed(raw) > 14'sd2047 || $signed(raw) < -14'sd2048;
            w = o ? {12{~raw[13]}} : raw[11:0] ^ 12'h800;
            fmt = off ? 14'h0000 : {v, o, w ^ {tw, 11'h000}};
        end
    endfunction
    task check(input [47:0] nm, input [13:0] e, input [13:0] s);
        begin
            check_count = check_count + 1;
            if (s !== e) begin
                failures = failures + 1;
                $display("[ERR] %s expected %h seen %h", nm, e, s);
            end
        end
    endtask
    task finish_test;
        begin
            $display("checks %0d failures %0d", check_count, failures);
            if (failures == 0 && check_count > 0) $display("[ PASS ]");
            else $display("[ FAIL ]");
            $finish;
        end
    endtask
    // boundary values near both full-scale limits, mixed with wide randoms
    task sample;
        reg v;
        reg stab_mode;
        begin
            raw_a = 14'(($urandom % 2) ? $urandom : 14'h07fe + $urandom % 4);
            raw_b = 14'(($urandom % 2) ? $urandom : 14'h37fe + $urandom % 4);
            oe_a_n = ($urandom % 4) == 0;
            oe_b_n = ($urandom % 4) == 0;
            // stabilizer on: samples inside the relock window come out marked invalid
            stab_mode = (mode_level == 2'h1) || (mode_level == 2'h2);
            v = !stab_mode || (n * 2 * half_cycles > relock_cycles);
            exp_q.push_back({fmt(raw_a, mode_level[1], oe_a_n, v),
                fmt(raw_b, mode_level[1], oe_b_n, v)});
            pin = 1'b1;
            repeat (half_cycles) @(posedge clk);
            #1 pin = 1'b0;
            repeat (half_cycles) @(posedge clk);
            #1;
        end
    endtask
    always @(got) begin
        check("chan_a", exp_q[0][27:14], cap[27:14]);
        check("chan_b", exp_q[0][13:0], cap[13:0]);
        void'(exp_q.pop_front());
    end
    initial begin
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 5000) begin
            failures = failures + 1;
            finish_test;
        end
    end
    initial begin
        n = $urandom(95033);
        repeat (12) @(posedge clk);
        #1 arst_n = 1'b1;
        for (m = 0; m < 4; m = m + 1) begin
            mode_level = m[1:0];
            // pin stands still long enough to drop stabilizer lock
            repeat (stop_cycles) @(posedge clk);
            #1;
            check("twos", {13'h0000, m > 1}, {13'h0000, twos});
            check("stab", {13'h0000, m == 1 || m == 2}, {13'h0000, stab});
            for (n = 0; n < 20; n = n + 1) sample;
            $display("mode %0d test done", m);
        end
        finish_test;
    end
endmodule // dual_adc_fmt_test
